// [rtl/hbridge_motor_control_logic.sv]
// What this block does
// RL1: both inputs low: sleep, outputs high-Z
// RL2: any input high wakes; fault pulses low
// RL3: decode forward, reverse, brake as tabled
// RL4: run entry restarts duty at zero, ramps
// RL5: host pwm holds one input high
// RL6: quarter output versus setpoint steers duty
// RL7: on time drives; off time both high-sides
// RL8: supply below setting: full duty, unregulated
// RL9: sense over limit 3 us cuts duty
// RL10: limit held 275 ms raises fault
// RL11: limit fault cleared only by sleep
// RL12: clamp past deglitch latches full shutdown
// RL13: overcurrent from all four switches ORed, one shared deglitch
// RL14: over-temperature disables bridge until cleared
// RL15: undervoltage resets logic, fault low
// RL16: fault released when nothing pending
// RL17: ramp counter cleared in sleep, brake
`timescale 1ns/1ns
`default_nettype none
`include "bridge_regs.svh"
module hbridge_motor_control_logic
	import bridge_pkg::*;
#(
	parameter int ILIM_FAULT_CYC = `ILIM_FAULT_CYC,
	parameter int RAMP_FULL_CYC  = `RAMP_FULL_CYC,
	parameter int PWM_PERIOD_CYC = `PWM_PERIOD_CYC
)(
	// clock, reset (reset is the supply-low lockout), enable
	input  wire logic CLK_IN,
	input  wire logic NRST_IN,
	input  wire logic CE_IN,
	// host bridge commands
	input  wire logic BRIDGE_CTRL_A_IN,
	input  wire logic BRIDGE_CTRL_B_IN,
	// analog comparator results
	input  wire logic CURRENT_SENSE_IN,
	input  wire logic REG_HIGH_IN,
	input  wire logic REG_LOW_IN,
	input  wire logic SUPPLY_ABOVE_SET_IN,
	input  wire logic OCP_HS_A_IN,
	input  wire logic OCP_LS_A_IN,
	input  wire logic OCP_HS_B_IN,
	input  wire logic OCP_LS_B_IN,
	input  wire logic THERMAL_SHUTDOWN_GUARD_IN,
	// power stage gate drives
	output logic      BRIDGE_OUT_A_HS_OUT,
	output logic      BRIDGE_OUT_A_LS_OUT,
	output logic      BRIDGE_OUT_B_HS_OUT,
	output logic      BRIDGE_OUT_B_LS_OUT,
	output logic      SLEEP_OUT,
	// open-drain fault pin: low enable means pulled low
	output logic      ERROR_FLAG_LOW_OUT,
	output logic      ERROR_FLAG_LOW_OE_N_OUT
);
	initial
	begin
		if (PWM_PERIOD_CYC < 2 || PWM_PERIOD_CYC > 4096)
			$error("pwm period out of range");
		if (RAMP_FULL_CYC < 256 || ILIM_FAULT_CYC < 1)
			$error("ramp or fault count too small");
	end

	localparam int RAMP_STEP_CYC = RAMP_FULL_CYC / 256;
	localparam int DLY_W = 20;
	localparam int LONG_W = 32;

	function automatic logic [1:0] over_dur(input logic [DLY_W-1:0] c, input int lim);
		over_dur = {1'b0, (c >= DLY_W'(lim))};
	endfunction

	////////////////////////////////////////////////////////////////////
	// input synchronisers for every command and sense input arriving from outside
	sense_t     sense;
	logic [1:0] ctrl;

	pin_sync #(.WIDTH(11)) u_sync (
		.clk_in     (CLK_IN),
		.nrst_in    (NRST_IN),
		.ce_in      (CE_IN),
		.raw_in     ({BRIDGE_CTRL_A_IN, BRIDGE_CTRL_B_IN,
		              OCP_HS_A_IN, OCP_LS_A_IN, OCP_HS_B_IN, OCP_LS_B_IN,
		              THERMAL_SHUTDOWN_GUARD_IN, CURRENT_SENSE_IN,
		              REG_HIGH_IN, REG_LOW_IN, SUPPLY_ABOVE_SET_IN}),
		.stable_out ({ctrl, sense})
	);

	////////////////////////////////////////////////////////////////////
	// mode decode and protection state
	bridge_mode_t              mode;
	bridge_mode_t              next_mode;
	logic                      ocp_latched;
	logic                      next_ocp_latched;
	logic                      ilim_fault;
	logic                      next_ilim_fault;
	logic [DLY_W-1:0]          ocp_cnt;
	logic [DLY_W-1:0]          next_ocp_cnt;
	logic [DLY_W-1:0]          ilim_dg_cnt;
	logic [DLY_W-1:0]          next_ilim_dg_cnt;
	logic [LONG_W-1:0]         ilim_cnt;
	logic [LONG_W-1:0]         next_ilim_cnt;
	logic [DLY_W-1:0]          wake_cnt;
	logic [DLY_W-1:0]          next_wake_cnt;
	logic                      ilim_active;
	logic                      any_ocp;

	always_comb
	begin
		// RL3 decode
		case (ctrl)
			2'b10:   next_mode = ST_FORWARD; // see RL3
			2'b01:   next_mode = ST_REVERSE; // see RL3
			2'b11:   next_mode = ST_BRAKE; // see RL3
			default: next_mode = ST_SLEEP; // see RL1
		endcase

		// all four switch clamps ORed into one deglitch counter
		any_ocp = sense.ocp_hs_a | sense.ocp_ls_a | sense.ocp_hs_b | sense.ocp_ls_b; // see RL13
		next_ocp_cnt = any_ocp ? ocp_cnt + DLY_W'(1) : '0;
		if (over_dur(ocp_cnt, `OCP_DEGLITCH_CYC) != 2'b00)
			next_ocp_cnt = ocp_cnt;
		// only a power cycle (reset) clears this
		next_ocp_latched = ocp_latched | (over_dur(ocp_cnt, `OCP_DEGLITCH_CYC) != 2'b00); // see RL12

		// current limit deglitch
		next_ilim_dg_cnt = sense.ilim ? ilim_dg_cnt : '0;
		if (sense.ilim && over_dur(ilim_dg_cnt, `ILIM_DEGLITCH_CYC) == 2'b00)
			next_ilim_dg_cnt = ilim_dg_cnt + DLY_W'(1);
		ilim_active = over_dur(ilim_dg_cnt, `ILIM_DEGLITCH_CYC) != 2'b00; // see RL9

		// long persistence timer; bridge keeps running meanwhile
		next_ilim_cnt = (ilim_active && mode != ST_SLEEP) ? ilim_cnt : '0;
		if (ilim_active && mode != ST_SLEEP && ilim_cnt < LONG_W'(ILIM_FAULT_CYC))
			next_ilim_cnt = ilim_cnt + LONG_W'(1); // see RL10
		next_ilim_fault = ilim_fault | (ilim_cnt >= LONG_W'(ILIM_FAULT_CYC));
		if (next_mode == ST_SLEEP)
			next_ilim_fault = 1'b0; // see RL11

		// wake pulse on every sleep exit
		next_wake_cnt = (wake_cnt != '0) ? wake_cnt - DLY_W'(1) : '0;
		if (mode == ST_SLEEP && next_mode != ST_SLEEP)
			next_wake_cnt = DLY_W'(`WAKE_PULSE_CYC); // see RL2
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			mode        <= ST_SLEEP;
			ocp_latched <= 1'b0;
			ilim_fault  <= 1'b0;
			ocp_cnt     <= '0;
			ilim_dg_cnt <= '0;
			ilim_cnt    <= '0;
			wake_cnt    <= '0;
		end
		else if (CE_IN)
		begin
			mode        <= next_mode;
			ocp_latched <= next_ocp_latched;
			ilim_fault  <= next_ilim_fault;
			ocp_cnt     <= next_ocp_cnt;
			ilim_dg_cnt <= next_ilim_dg_cnt;
			ilim_cnt    <= next_ilim_cnt;
			wake_cnt    <= next_wake_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// regulator, soft-start ramp and pwm
	logic [`DUTY_W-1:0] target;
	logic [`DUTY_W-1:0] next_target;
	logic [`DUTY_W-1:0] duty;
	logic [`DUTY_W-1:0] next_duty;
	logic [DLY_W-1:0]   ramp_cnt;
	logic [DLY_W-1:0]   next_ramp_cnt;
	logic [11:0]        pwm_cnt;
	logic [11:0]        next_pwm_cnt;
	logic               pwm_on;
	logic               period_end;
	logic               running;

	always_comb
	begin
		running    = (mode == ST_FORWARD) || (mode == ST_REVERSE);
		period_end = pwm_cnt == 12'(PWM_PERIOD_CYC - 1);
		next_pwm_cnt = period_end ? 12'h000 : pwm_cnt + 12'h001;

		// comparators report the quarter-scaled averaged output against setpoint
		next_target = target;
		if (period_end)
		begin
			if (sense.reg_low && target != `DUTY_FULL)
				next_target = target + `DUTY_W'(1); // see RL6
			else if (sense.reg_high && target != `DUTY_ZERO)
				next_target = target - `DUTY_W'(1); // see RL6
		end
		if (!sense.supply_above_set)
			next_target = `DUTY_FULL; // see RL8
		if (ilim_active && period_end)
		begin
			next_target = `DUTY_ZERO;
			if (target != `DUTY_ZERO)
				next_target = target - `DUTY_W'(1); // see RL9
		end

		// soft start: duty climbs one step per interval, never above target
		next_ramp_cnt = (ramp_cnt >= DLY_W'(RAMP_STEP_CYC - 1)) ? '0 : ramp_cnt + DLY_W'(1);
		next_duty = duty;
		if (duty > target)
			next_duty = target;
		else if (duty < target && ramp_cnt == '0)
			next_duty = duty + `DUTY_W'(1); // see RL17
		if (!running)
		begin
			next_duty     = `DUTY_ZERO; // see RL4
			next_ramp_cnt = '0; // see RL17
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			target   <= `DUTY_ZERO;
			duty     <= `DUTY_ZERO;
			ramp_cnt <= '0;
			pwm_cnt  <= 12'h000;
		end
		else if (CE_IN)
		begin
			target   <= next_target;
			duty     <= next_duty;
			ramp_cnt <= next_ramp_cnt;
			pwm_cnt  <= next_pwm_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// gate drive and fault pin
	half_drive_t next_a;
	half_drive_t next_b;
	logic        next_sleep;
	logic        next_fault_low;
	logic        disable_all;

	always_comb
	begin
		// full duty keeps the bridge on for the whole period
		pwm_on = (duty == `DUTY_FULL) ||
		         (32'(pwm_cnt) * 256 < 32'(duty) * PWM_PERIOD_CYC);
		disable_all = ocp_latched || sense.thermal; // see RL12 see RL14
		next_sleep  = mode == ST_SLEEP;
		next_a = '{hs: 1'b0, ls: 1'b0};
		next_b = '{hs: 1'b0, ls: 1'b0};
		if (!disable_all)
		begin
			case (mode)
				ST_FORWARD:
				begin
					next_a = pwm_on ? '{hs: 1'b1, ls: 1'b0} : '{hs: 1'b1, ls: 1'b0}; // see RL7
					next_b = pwm_on ? '{hs: 1'b0, ls: 1'b1} : '{hs: 1'b1, ls: 1'b0}; // see RL7
				end
				ST_REVERSE:
				begin
					next_a = pwm_on ? '{hs: 1'b0, ls: 1'b1} : '{hs: 1'b1, ls: 1'b0}; // see RL7
					next_b = '{hs: 1'b1, ls: 1'b0}; // see RL3
				end
				ST_BRAKE:
				begin
					next_a = '{hs: 1'b1, ls: 1'b0}; // see RL3
					next_b = '{hs: 1'b1, ls: 1'b0}; // see RL3
				end
				ST_SLEEP:
				begin
					next_a = '{hs: 1'b0, ls: 1'b0}; // see RL1
					next_b = '{hs: 1'b0, ls: 1'b0}; // see RL1
				end
				default:
				begin
					next_a = '{hs: 1'b0, ls: 1'b0};
					next_b = '{hs: 1'b0, ls: 1'b0};
				end
			endcase
		end
		next_fault_low = disable_all || ilim_fault || (wake_cnt != '0); // see RL16
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			// lockout holds everything off with fault pulled low
			BRIDGE_OUT_A_HS_OUT     <= 1'b0; // see RL15
			BRIDGE_OUT_A_LS_OUT     <= 1'b0;
			BRIDGE_OUT_B_HS_OUT     <= 1'b0;
			BRIDGE_OUT_B_LS_OUT     <= 1'b0;
			SLEEP_OUT               <= 1'b1;
			ERROR_FLAG_LOW_OUT      <= 1'b0;
			ERROR_FLAG_LOW_OE_N_OUT <= 1'b0; // see RL15
		end
		else if (CE_IN)
		begin
			BRIDGE_OUT_A_HS_OUT     <= next_a.hs;
			BRIDGE_OUT_A_LS_OUT     <= next_a.ls;
			BRIDGE_OUT_B_HS_OUT     <= next_b.hs;
			BRIDGE_OUT_B_LS_OUT     <= next_b.ls;
			SLEEP_OUT               <= next_sleep;
			ERROR_FLAG_LOW_OUT      <= 1'b0;
			ERROR_FLAG_LOW_OE_N_OUT <= !next_fault_low;
		end
	end
endmodule // hbridge_motor_control_logic
`default_nettype wire

// [rtl/bridge_regs.svh]
`ifndef BRIDGE_REGS_SVH
`define BRIDGE_REGS_SVH
// clock rate and derived counts
`define CLK_HZ            10000000
`define PWM_FREQ_HZ       44500
`define PWM_PERIOD_CYC    (`CLK_HZ / `PWM_FREQ_HZ)
`define RAMP_FULL_MS      12
`define RAMP_FULL_CYC     ((`CLK_HZ / 1000) * `RAMP_FULL_MS)
`define ILIM_DEGLITCH_US  3
`define ILIM_DEGLITCH_CYC ((`CLK_HZ / 1000000) * `ILIM_DEGLITCH_US)
`define ILIM_FAULT_MS     275
`define ILIM_FAULT_CYC    ((`CLK_HZ / 1000) * `ILIM_FAULT_MS)
`define OCP_DEGLITCH_US   2
`define OCP_DEGLITCH_CYC  ((`CLK_HZ / 1000000) * `OCP_DEGLITCH_US)
`define WAKE_PULSE_US     10
`define WAKE_PULSE_CYC    ((`CLK_HZ / 1000000) * `WAKE_PULSE_US)
`define DUTY_W            8
`define DUTY_FULL         8'hff
`define DUTY_ZERO         8'h00
`endif

// [rtl/bridge_pkg.sv]
package bridge_pkg;
	typedef enum logic [3:0] {
		ST_SLEEP   = 4'b0001,
		ST_FORWARD = 4'b0010,
		ST_REVERSE = 4'b0100,
		ST_BRAKE   = 4'b1000
	} bridge_mode_t;

	// one half-bridge: high side on, low side on (never both)
	typedef struct packed {
		logic hs;
		logic ls;
	} half_drive_t;

	typedef struct packed {
		logic ocp_hs_a;
		logic ocp_ls_a;
		logic ocp_hs_b;
		logic ocp_ls_b;
		logic thermal;
		logic ilim;
		logic reg_high;
		logic reg_low;
		logic supply_above_set;
	} sense_t;
endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module pin_sync
	import bridge_pkg::*;
#(
	parameter int WIDTH = 9
)(
	// clock, reset and enable
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	input  wire logic             ce_in,
	// data
	input  wire logic [WIDTH-1:0] raw_in,
	output logic      [WIDTH-1:0] stable_out
);
	initial
	begin
		if (WIDTH < 1)
			$error("pin_sync width must be positive");
	end

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_stable;

	// a change counts only once stages two and three agree
	always_comb
	begin
		for (int i = 0; i < WIDTH; i++)
			next_stable[i] = (s2[i] == s3[i]) ? s3[i] : stable_out[i];
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			s1         <= '0;
			s2         <= '0;
			s3         <= '0;
			stable_out <= '0;
		end
		else if (ce_in)
		begin
			s1         <= raw_in;
			s2         <= s1;
			s3         <= s2;
			stable_out <= next_stable;
		end
	end
endmodule // pin_sync
`default_nettype wire

// [verification/hbridge_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module hbridge_checker #(
	parameter int ILIM_FAULT_CYC = 200
)(
	// clock, reset
	input wire logic CLK_IN, NRST_IN,
	// sense inputs
	input wire logic CURRENT_SENSE_IN, THERMAL_SHUTDOWN_GUARD_IN,
	input wire logic OCP_HS_A_IN, OCP_LS_A_IN, OCP_HS_B_IN, OCP_LS_B_IN,
	// gate drives and fault pin
	input wire logic BRIDGE_OUT_A_HS_OUT, BRIDGE_OUT_A_LS_OUT,
	input wire logic BRIDGE_OUT_B_HS_OUT, BRIDGE_OUT_B_LS_OUT,
	input wire logic SLEEP_OUT, ERROR_FLAG_LOW_OUT, ERROR_FLAG_LOW_OE_N_OUT
);
	// margin covers input sync, limit deglitch and output register
	localparam int LIM_AT = ILIM_FAULT_CYC + 64;
	wire logic ahs = BRIDGE_OUT_A_HS_OUT;
	wire logic als = BRIDGE_OUT_A_LS_OUT;
	wire logic bhs = BRIDGE_OUT_B_HS_OUT;
	wire logic bls = BRIDGE_OUT_B_LS_OUT;
	wire logic off = !(ahs | als | bhs | bls);
	wire logic oen = ERROR_FLAG_LOW_OE_N_OUT;
	wire logic overcurrent_shutdown = OCP_HS_A_IN | OCP_LS_A_IN | OCP_HS_B_IN | OCP_LS_B_IN;
	logic [5:0]  ocp_cnt, next_ocp_cnt;
	logic [15:0] lim_cnt, next_lim_cnt;
	logic        ocp_seen, next_ocp_seen;
	////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_ocp_cnt = !overcurrent_shutdown ? 6'h00 : (ocp_cnt == 6'h28) ? ocp_cnt : ocp_cnt + 6'h01;
		next_ocp_seen = ocp_seen | (ocp_cnt == 6'h28);
		next_lim_cnt = (!CURRENT_SENSE_IN || SLEEP_OUT) ? 16'h0000 :
			(lim_cnt == 16'hffff) ? lim_cnt : lim_cnt + 16'h0001;
	end
	always_ff @(posedge CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
			{ocp_cnt, ocp_seen, lim_cnt} <= '0;
		else
			{ocp_cnt, ocp_seen, lim_cnt} <= {next_ocp_cnt, next_ocp_seen, next_lim_cnt};
	end
	////////////////////////////////////////////////////////////////
	default clocking dcb @(posedge CLK_IN);
	endclocking
	default disable iff (!NRST_IN);
	sequence wake_exit;
		$fell(SLEEP_OUT);
	endsequence
	sequence pulse_low;
		(!oen) [*8];
	endsequence
	a_reset_quiet: assert property ($rose(NRST_IN) |-> SLEEP_OUT && off && !oen)
		else $error("reset state wrong");
	a_sleep_hiz: assert property (SLEEP_OUT [*3] |-> off)
		else $error("gates on in sleep");
	a_wake_pulse: assert property (wake_exit |-> ##[0:2] pulse_low)
		else $error("no wake pulse");
	a_dir_pair: assert property ((als || bls) |-> (als ? bhs && !ahs && !bls : ahs && !bhs))
		else $error("bad gate pair");
	a_thermal_off: assert property (THERMAL_SHUTDOWN_GUARD_IN [*6] |-> ##[0:4] (off && !oen))
		else $error("thermal not off");
	a_ocp_latch: assert property (ocp_seen |-> off && !oen)
		else $error("overcurrent not latched");
	a_ilim_fault: assert property (lim_cnt == 16'(LIM_AT) |-> !oen)
		else $error("limit fault missing");
	a_drain_zero: assert property (!ERROR_FLAG_LOW_OUT)
		else $error("fault data not low");
endmodule // hbridge_checker
`default_nettype wire

// [verification/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model (
	// clock and fault pin
	input  wire logic clk_in,
	input  wire logic fault_in,
	// bridge commands
	output logic      ctrl_a_out,
	output logic      ctrl_b_out
);
	initial {ctrl_a_out, ctrl_b_out} = 2'b00;
	// caller is already just past an edge; 00 also clears a limit fault
	task automatic cmd(input logic [1:0] ab);
		{ctrl_a_out, ctrl_b_out} = ab;
	endtask
	// a held high so b pulses swap drive and brake, never sleep
	task automatic pwm(input int n, input int half, output int lows);
		lows = 0;
		repeat (n)
		begin
			{ctrl_a_out, ctrl_b_out} = {1'b1, ~ctrl_b_out};
			repeat (half) @(posedge clk_in);
			#10;
			lows += (fault_in === 1'b1) ? 0 : 1;
		end
	endtask
endmodule // host_model
`default_nettype wire

// [verification/tb_hbridge_motor_control_logic.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_hbridge_motor_control_logic;
	logic       clk = 1'b0, nrst = 1'b0, sense = 1'b0, rh = 1'b0, rl = 1'b0;
	logic       sup = 1'b0, th = 1'b0, ce = 1'b1;
	logic [3:0] overcurrent_shutdown = 4'h0;
	logic       ahs, als, bhs, bls, slp, ed, oen, ca, cb;
	int         bad_count = 0;
	int         n_checks = 0;
	// pull-up: a released pin reads high, never the last driven value
	wire logic       pin = oen ? 1'b1 : ed;
	wire logic [3:0] g = {ahs, als, bhs, bls};
	wire logic [1:0] fs = {slp, pin};
	initial
	begin
		forever #50 clk = ~clk;
	end
	hbridge_motor_control_logic #(.ILIM_FAULT_CYC(200), .RAMP_FULL_CYC(2560),
		.PWM_PERIOD_CYC(16)) hbridge_motor_control_logic_inst (
		.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
		.BRIDGE_CTRL_A_IN(ca), .BRIDGE_CTRL_B_IN(cb),
		.CURRENT_SENSE_IN(sense), .REG_HIGH_IN(rh), .REG_LOW_IN(rl),
		.SUPPLY_ABOVE_SET_IN(sup), .THERMAL_SHUTDOWN_GUARD_IN(th),
		.OCP_HS_A_IN(overcurrent_shutdown[0]), .OCP_LS_A_IN(overcurrent_shutdown[1]), .OCP_HS_B_IN(overcurrent_shutdown[2]), .OCP_LS_B_IN(overcurrent_shutdown[3]),
		.BRIDGE_OUT_A_HS_OUT(ahs), .BRIDGE_OUT_A_LS_OUT(als),
		.BRIDGE_OUT_B_HS_OUT(bhs), .BRIDGE_OUT_B_LS_OUT(bls), .SLEEP_OUT(slp),
		.ERROR_FLAG_LOW_OUT(ed), .ERROR_FLAG_LOW_OE_N_OUT(oen));
	host_model host_model_inst (.clk_in(clk), .fault_in(pin), .ctrl_a_out(ca), .ctrl_b_out(cb));
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// an unknown gate counts as on, so it cannot pass for zero duty
	task automatic on_cnt(output int n);
		n = 0;
		repeat (16)
		begin
			cyc(1);
			n += (bls === 1'b0) ? 0 : 1;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		host_model_inst.cmd(2'b00);
		nrst = 1'b0;
		cyc(10);
		chk("in reset", 8'h20, 8'({slp, g, pin}));
		nrst = 1'b1;
		cyc(10);
		chk("idle", 8'h21, 8'({slp, g, pin}));
	endtask
	task automatic t_dirs();
		int n;
		host_model_inst.cmd(2'b10);
		cyc(10);
		chk("wake", 8'h00, 8'(fs));
		cyc(3000);
		chk("forward", 8'h09, 8'(g));
		on_cnt(n);
		chk("full duty", 8'h10, 8'(n));
		host_model_inst.cmd(2'b01);
		cyc(3000);
		chk("reverse", 8'h06, 8'(g));
		host_model_inst.cmd(2'b11);
		cyc(200);
		chk("brake", 8'h0a, 8'(g));
		chk("flag", 8'h01, 8'(fs));
	endtask
	task automatic t_hostpwm();
		int lows;
		host_model_inst.pwm(20, 40, lows);
		chk("host pwm lows", 8'h00, 8'(lows));
	endtask
	task automatic t_ramp();
		int n;
		sup = 1'b1;
		rl = 1'b1;
		host_model_inst.cmd(2'b10);
		cyc(8);
		// a freshly restarted ramp still gives one on cycle per pwm period
		on_cnt(n);
		chk("duty start", 8'h01, 8'(n));
		cyc(5000);
		on_cnt(n);
		chk("duty up", 8'h01, {7'h00, n > 8});
		rl = 1'b0;
		rh = 1'b1;
		cyc(5000);
		on_cnt(n);
		chk("duty down", 8'h00, 8'(n));
		rh = 1'b0;
		rl = 1'b1;
		cyc(3000);
		on_cnt(n);
		chk("duty rise", 8'h01, {7'h00, n > 8});
	endtask
	task automatic t_ilim();
		int n;
		sense = 1'b1;
		cyc(300);
		chk("limit fault", 8'h02, 8'({ahs, pin}));
		cyc(4000);
		on_cnt(n);
		chk("limit duty", 8'h00, 8'(n));
		sense = 1'b0;
		cyc(50);
		chk("fault held", 8'h00, 8'(pin));
		host_model_inst.cmd(2'b00);
		cyc(10);
		chk("sleep clear", 8'h03, 8'(fs));
	endtask
	task automatic t_thermal();
		host_model_inst.cmd(2'b10);
		cyc(200);
		th = 1'b1;
		cyc(10);
		chk("hot", 8'h00, 8'({g, pin}));
		th = 1'b0;
		cyc(10);
		chk("cool", 8'h03, 8'({ahs, pin}));
	endtask
	// a low enable must hold even the input stages, so no command leaks through
	task automatic t_freeze();
		host_model_inst.cmd(2'b00);
		cyc(20);
		ce = 1'b0;
		host_model_inst.cmd(2'b11);
		cyc(20);
		chk("frozen", 8'h21, 8'({slp, g, pin}));
		ce = 1'b1;
		cyc(10);
		chk("thawed", 8'h14, 8'({slp, g, pin}));
	endtask
	task automatic t_ocp();
		for (int i = 0; i < 4; i++)
		begin
			t_reset();
			host_model_inst.cmd(2'b10);
			cyc(200);
			overcurrent_shutdown = 4'h1 << i;
			cyc(10);
			overcurrent_shutdown = 4'h0;
			cyc(10);
			chk("ocp glitch", 8'h01, 8'(ahs));
			overcurrent_shutdown = 4'h1 << i;
			cyc(45);
			overcurrent_shutdown = 4'h0;
			cyc(20);
			chk("ocp latch", 8'h00, 8'({g, pin}));
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		t_reset();
		t_dirs();
		t_hostpwm();
		t_ramp();
		t_ilim();
		t_thermal();
		t_freeze();
		t_ocp();
		tally_and_finish();
	end
	// about twice the expected run, so a stuck wait cannot hang it
	initial
	begin
		#6000000;
		bad_count++;
		tally_and_finish();
	end
endmodule // tb_hbridge_motor_control_logic
bind hbridge_motor_control_logic hbridge_checker #(.ILIM_FAULT_CYC(ILIM_FAULT_CYC))
	hbridge_checker_inst (
	.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CURRENT_SENSE_IN(CURRENT_SENSE_IN),
	.THERMAL_SHUTDOWN_GUARD_IN(THERMAL_SHUTDOWN_GUARD_IN),
	.OCP_HS_A_IN(OCP_HS_A_IN), .OCP_LS_A_IN(OCP_LS_A_IN),
	.OCP_HS_B_IN(OCP_HS_B_IN), .OCP_LS_B_IN(OCP_LS_B_IN),
	.BRIDGE_OUT_A_HS_OUT(BRIDGE_OUT_A_HS_OUT), .BRIDGE_OUT_A_LS_OUT(BRIDGE_OUT_A_LS_OUT),
	.BRIDGE_OUT_B_HS_OUT(BRIDGE_OUT_B_HS_OUT), .BRIDGE_OUT_B_LS_OUT(BRIDGE_OUT_B_LS_OUT),
	.SLEEP_OUT(SLEEP_OUT), .ERROR_FLAG_LOW_OUT(ERROR_FLAG_LOW_OUT),
	.ERROR_FLAG_LOW_OE_N_OUT(ERROR_FLAG_LOW_OE_N_OUT));
`default_nettype wire
